// ===== amcr_pkg.sv
// Constants, register map and types for the converter mode, clock and result block.
package amcr_pkg;

  // Clocking and the internal oscillator.
  localparam int          CLK_FREQ_HZ    = 200_000_000;
  localparam int          OSC_FREQ_HZ    = 76_800;
  localparam logic [11:0] OSC_HALF_CYC   = 12'(CLK_FREQ_HZ / (2 * OSC_FREQ_HZ));

  // Register word indices; the byte address is four times the index.
  localparam logic [5:0]  IDX_CTRL       = 6'h01;
  localparam logic [5:0]  IDX_RESULT     = 6'h02;
  localparam logic [5:0]  IDX_STATUS     = 6'h04;

  // Field positions in the control register.
  localparam int          CTRL_CLK_LSB   = 0;
  localparam int          CTRL_MODE_LSB  = 2;
  localparam int          CTRL_RATIO_LSB = 6;

  // Field positions in the status register.
  localparam int          STAT_STATE_LSB = 0;
  localparam int          STAT_BUSY_BIT  = 2;

  // Converter sequencing lengths in main clock ticks.
  localparam logic [15:0] CONV_TICKS     = 16'h0010;
  localparam logic [15:0] CAL_TICKS      = 16'h0040;

  typedef enum logic [3:0] {
    MODE_CONT      = 4'b0000,
    MODE_SINGLE    = 4'b0001,
    MODE_LOW_POWER_HOLD      = 4'b0010,
    MODE_PDOWN     = 4'b0011,
    MODE_IDLE      = 4'b0100,
    MODE_CAL_IOFS  = 4'b0101,
    MODE_CAL_IGAIN = 4'b0110,
    MODE_CAL_SOFS  = 4'b0111,
    MODE_CAL_SGAIN = 4'b1000,
    MODE_DUTY      = 4'b1001,
    MODE_SYNC_IDLE = 4'b1010,
    MODE_SYNC_LOW_POWER_HOLD = 4'b1011
  } amcr_mode_t;

  typedef enum logic [1:0] {
    CLK_INT_QUIET = 2'b00,
    CLK_INT_OUT   = 2'b01,
    CLK_EXT_DIRECT = 2'b10,
    CLK_EXT_HALF  = 2'b11
  } amcr_clksel_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW_POWER_HOLD = 2'b01,
    ST_CONV = 2'b10,
    ST_CAL  = 2'b11
  } amcr_state_t;

  // Reset values.
  localparam amcr_clksel_t CLK_SEL_RST   = CLK_INT_QUIET;
  localparam amcr_mode_t   MODE_RST      = MODE_IDLE;
  localparam logic [1:0]   RATIO_RST     = 2'h0;
  localparam logic [15:0]  RESULT_RST    = 16'h0000;

endpackage : amcr_pkg

// ===== amcr_core.sv
// Converter mode sequencing, main clock selection and result register with a Wishbone slave.
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Code 0101: internal offset calibration, then idle
// - Code 0110: internal gain calibration, then idle
// - Code 0111: system offset calibration, then idle
// - Code 1000: system gain calibration, then idle
// - Code 1001: alternate conversion and standby by ratio
// - Code 1010: convert per sync fall, idle between
// - Code 1011: convert per sync fall, standby between
// - Clock select field resets to zero, picks source
// - Select 00: internal oscillator, pin not driven
// - Select 01: internal oscillator, driven on pin
// - Select 10: pin clock used directly
// - Select 11: pin clock divided by two
// - Result register holds newest conversion, read-only
// - Result at index 0x02, zero after reset
// - Idle holds filter and modulator in reset
// - Code 0010 is standby low-power state
module amcr_core (
  input  wire logic        clk_i,            // System clock, 200 MHz.
  input  wire logic        rst_i,            // Synchronous reset, active high.
  input  wire logic        wb_cyc_i,         // Wishbone cycle.
  input  wire logic        wb_stb_i,         // Wishbone strobe.
  input  wire logic        wb_we_i,          // Wishbone write enable.
  input  wire logic [7:0]  wb_adr_i,         // Wishbone byte address.
  input  wire logic [3:0]  wb_sel_i,         // Wishbone byte selects.
  input  wire logic [31:0] wb_dat_i,         // Wishbone write data.
  output logic      [31:0] wb_dat_o,         // Wishbone read data.
  output logic             wb_ack_o,         // Wishbone acknowledge.
  input  wire logic        sync_n_i,         // Sync pin, falling edge starts a sequence.
  input  wire logic        clkpin_i,         // Clock pin input level.
  output logic             clkpin_o,         // Clock pin output level.
  output logic             clkpin_oe_o,      // Clock pin output enable.
  input  wire logic [15:0] sample_i,         // Conversion outcome from the filter.
  output logic             mclk_tick_o,      // One-cycle pulse per main clock period.
  output logic             filter_rst_o,     // Holds filter and modulator in reset.
  output logic             low_power_hold_o, // Standby low-power state.
  output logic             convert_o,        // Conversion in progress.
  output logic             cal_active_o,     // Calibration in progress.
  output logic      [1:0]  cal_kind_o        // Bit 0 gain, bit 1 system calibration.
);

  amcr_pkg::amcr_state_t  state_ff;
  amcr_pkg::amcr_mode_t   mode_ff;
  amcr_pkg::amcr_clksel_t clk_sel_ff;
  logic [1:0]             ratio_ff;
  logic [15:0]            result_ff;
  logic [15:0]            cnt_ff;
  logic                   ack_ff;
  logic [31:0]            dat_ff;
  logic                   mode_wr_ff;
  logic [11:0]            osc_cnt_ff;
  logic                   osc_lvl_ff;
  logic                   pin_d_ff;
  logic                   half_ff;
  logic                   tick_ff;
  logic                   sync_d_ff;
  logic                   req;
  logic                   bus_wr;
  logic                   ctrl_wr_lo;
  logic [5:0]             idx;
  logic [31:0]            nxt_dat;
  logic                   osc_rise;
  logic                   pin_rise;
  logic                   sync_fall;
  logic                   conv_done;
  logic                   cal_done;

  function automatic logic is_cal(input amcr_pkg::amcr_mode_t m);
    return (m == amcr_pkg::MODE_CAL_IOFS) || (m == amcr_pkg::MODE_CAL_IGAIN) ||
           (m == amcr_pkg::MODE_CAL_SOFS) || (m == amcr_pkg::MODE_CAL_SGAIN);
  endfunction : is_cal

  function automatic logic [15:0] low_power_hold_len(input logic [1:0] r);
    return (amcr_pkg::CONV_TICKS << ({1'b0, r} + 3'h1)) - amcr_pkg::CONV_TICKS;
  endfunction : low_power_hold_len

  function automatic amcr_pkg::amcr_state_t entry_state(input amcr_pkg::amcr_mode_t m);
    amcr_pkg::amcr_state_t s;
    s = amcr_pkg::ST_IDLE;
    if (is_cal(m)) begin
      s = amcr_pkg::ST_CAL;
    end else if (m == amcr_pkg::MODE_CONT || m == amcr_pkg::MODE_SINGLE ||
                 m == amcr_pkg::MODE_DUTY) begin
      s = amcr_pkg::ST_CONV;
    end else if (m == amcr_pkg::MODE_LOW_POWER_HOLD || m == amcr_pkg::MODE_SYNC_LOW_POWER_HOLD ||
                 m == amcr_pkg::MODE_PDOWN) begin
      s = amcr_pkg::ST_LOW_POWER_HOLD;
    end
    return s;
  endfunction : entry_state

  // Bus slave: ack one cycle after the request; writes land on the ack edge.
  assign req        = wb_cyc_i & wb_stb_i;
  assign bus_wr     = req & wb_we_i & ack_ff;
  assign idx        = wb_adr_i[7:2];
  assign ctrl_wr_lo = bus_wr & (idx == amcr_pkg::IDX_CTRL) & wb_sel_i[0];
  assign wb_ack_o   = ack_ff;
  assign wb_dat_o   = dat_ff;

  always_comb begin
    nxt_dat = 32'h0000_0000;
    case (idx)
      amcr_pkg::IDX_CTRL: begin
        nxt_dat[amcr_pkg::CTRL_CLK_LSB +: 2]   = clk_sel_ff;
        nxt_dat[amcr_pkg::CTRL_MODE_LSB +: 4]  = mode_ff;
        nxt_dat[amcr_pkg::CTRL_RATIO_LSB +: 2] = ratio_ff;
      end
      amcr_pkg::IDX_RESULT: begin
        nxt_dat[15:0] = result_ff;
      end
      amcr_pkg::IDX_STATUS: begin
        nxt_dat[amcr_pkg::STAT_STATE_LSB +: 2] = state_ff;
        nxt_dat[amcr_pkg::STAT_BUSY_BIT]       = cal_active_o;
      end
      default: begin
        nxt_dat = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req & ~ack_ff;
      if (req & ~ack_ff) begin
        dat_ff <= nxt_dat;
      end
    end
  end

  // Control register; a host write wins over the automatic return to idle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_sel_ff <= amcr_pkg::CLK_SEL_RST;
      mode_ff    <= amcr_pkg::MODE_RST;
      ratio_ff   <= amcr_pkg::RATIO_RST;
      mode_wr_ff <= 1'b0;
    end else begin
      mode_wr_ff <= ctrl_wr_lo;
      if (ctrl_wr_lo) begin
        clk_sel_ff <= amcr_pkg::amcr_clksel_t'(wb_dat_i[amcr_pkg::CTRL_CLK_LSB +: 2]);
        mode_ff    <= amcr_pkg::amcr_mode_t'(wb_dat_i[amcr_pkg::CTRL_MODE_LSB +: 4]);
        ratio_ff   <= wb_dat_i[amcr_pkg::CTRL_RATIO_LSB +: 2];
      end else if (cal_done) begin
        mode_ff <= amcr_pkg::MODE_IDLE;
      end
    end
  end

  // Internal oscillator: a square wave from the system clock.
  assign osc_rise = (osc_cnt_ff == amcr_pkg::OSC_HALF_CYC - 12'h001) & ~osc_lvl_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_cnt_ff <= 12'h000;
      osc_lvl_ff <= 1'b0;
    end else if (osc_cnt_ff == amcr_pkg::OSC_HALF_CYC - 12'h001) begin
      osc_cnt_ff <= 12'h000;
      osc_lvl_ff <= ~osc_lvl_ff;
    end else begin
      osc_cnt_ff <= osc_cnt_ff + 12'h001;
    end
  end

  assign clkpin_o    = osc_lvl_ff;
  assign clkpin_oe_o = (clk_sel_ff == amcr_pkg::CLK_INT_OUT);
  assign pin_rise    = clkpin_i & ~pin_d_ff;

  // Main clock tick from the selected source.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_d_ff <= 1'b0;
      half_ff  <= 1'b0;
      tick_ff  <= 1'b0;
    end else begin
      pin_d_ff <= clkpin_i;
      if (pin_rise && clk_sel_ff == amcr_pkg::CLK_EXT_HALF) begin
        half_ff <= ~half_ff;
      end
      case (clk_sel_ff)
        amcr_pkg::CLK_INT_QUIET:  tick_ff <= osc_rise;
        amcr_pkg::CLK_INT_OUT:    tick_ff <= osc_rise;
        amcr_pkg::CLK_EXT_DIRECT: tick_ff <= pin_rise;
        amcr_pkg::CLK_EXT_HALF:   tick_ff <= pin_rise & half_ff;
        default:                  tick_ff <= 1'b0;
      endcase
    end
  end

  assign mclk_tick_o = tick_ff;

  // Sequencer.
  assign sync_fall = sync_d_ff & ~sync_n_i;
  assign conv_done = (state_ff == amcr_pkg::ST_CONV) & tick_ff & ~mode_wr_ff &
                     (cnt_ff == amcr_pkg::CONV_TICKS - 16'h0001);
  assign cal_done  = (state_ff == amcr_pkg::ST_CAL) & tick_ff & ~mode_wr_ff &
                     (cnt_ff == amcr_pkg::CAL_TICKS - 16'h0001);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_d_ff <= 1'b1;
    end else begin
      sync_d_ff <= sync_n_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= amcr_pkg::ST_IDLE;
      cnt_ff   <= 16'h0000;
    end else if (mode_wr_ff) begin
      state_ff <= entry_state(mode_ff);
      cnt_ff   <= 16'h0000;
    end else begin
      case (state_ff)
        amcr_pkg::ST_CONV: begin
          if (conv_done) begin
            cnt_ff <= 16'h0000;
            case (mode_ff)
              amcr_pkg::MODE_CONT:      state_ff <= amcr_pkg::ST_CONV;
              amcr_pkg::MODE_DUTY:      state_ff <= amcr_pkg::ST_LOW_POWER_HOLD;
              amcr_pkg::MODE_SYNC_LOW_POWER_HOLD: state_ff <= amcr_pkg::ST_LOW_POWER_HOLD;
              default:                  state_ff <= amcr_pkg::ST_IDLE;
            endcase
          end else if (tick_ff) begin
            cnt_ff <= cnt_ff + 16'h0001;
          end
        end
        amcr_pkg::ST_LOW_POWER_HOLD: begin
          if (mode_ff == amcr_pkg::MODE_DUTY && tick_ff) begin
            if (cnt_ff >= low_power_hold_len(ratio_ff) - 16'h0001) begin
              state_ff <= amcr_pkg::ST_CONV;
              cnt_ff   <= 16'h0000;
            end else begin
              cnt_ff <= cnt_ff + 16'h0001;
            end
          end else if (mode_ff == amcr_pkg::MODE_SYNC_LOW_POWER_HOLD && sync_fall) begin
            state_ff <= amcr_pkg::ST_CONV;
            cnt_ff   <= 16'h0000;
          end
        end
        amcr_pkg::ST_IDLE: begin
          if (mode_ff == amcr_pkg::MODE_SYNC_IDLE && sync_fall) begin
            state_ff <= amcr_pkg::ST_CONV;
            cnt_ff   <= 16'h0000;
          end
        end
        amcr_pkg::ST_CAL: begin
          if (cal_done) begin
            state_ff <= amcr_pkg::ST_IDLE;
            cnt_ff   <= 16'h0000;
          end else if (tick_ff) begin
            cnt_ff <= cnt_ff + 16'h0001;
          end
        end
        default: begin
          state_ff <= amcr_pkg::ST_IDLE;
          cnt_ff   <= 16'h0000;
        end
      endcase
    end
  end

  // Result register, updated only by completed conversions.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_ff <= amcr_pkg::RESULT_RST;
    end else if (conv_done) begin
      result_ff <= sample_i;
    end
  end

  assign filter_rst_o     = (state_ff == amcr_pkg::ST_IDLE);
  assign low_power_hold_o = (state_ff == amcr_pkg::ST_LOW_POWER_HOLD);
  assign convert_o        = (state_ff == amcr_pkg::ST_CONV);
  assign cal_active_o     = (state_ff == amcr_pkg::ST_CAL);
  assign cal_kind_o       = {(mode_ff == amcr_pkg::MODE_CAL_SOFS) ||
                             (mode_ff == amcr_pkg::MODE_CAL_SGAIN),
                             (mode_ff == amcr_pkg::MODE_CAL_IGAIN) ||
                             (mode_ff == amcr_pkg::MODE_CAL_SGAIN)};

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_mode_set(logic [3:0] code);
    mode_wr_ff && (mode_ff == code);
  endsequence

  sequence s_sync_start;
    sync_fall && !mode_wr_ff;
  endsequence

  property p_cal_start(logic [3:0] code, logic [1:0] kind);
    s_mode_set(code) |=> (state_ff == amcr_pkg::ST_CAL) && (cal_kind_o == kind);
  endproperty

  a_cal_iofs_run: assert property (p_cal_start(4'h5, 2'h0))
    else $error("internal offset calibration did not start");
  a_cal_igain_run: assert property (p_cal_start(4'h6, 2'h1))
    else $error("internal gain calibration did not start");
  a_cal_sofs_run: assert property (p_cal_start(4'h7, 2'h2))
    else $error("system offset calibration did not start");
  a_cal_sgain_run: assert property (p_cal_start(4'h8, 2'h3))
    else $error("system gain calibration did not start");

  a_cal_back_idle: assert property (cal_done && !ctrl_wr_lo |=>
    (mode_ff == amcr_pkg::MODE_IDLE) && filter_rst_o)
    else $error("calibration did not return to idle");

  a_duty_to_low_power_hold: assert property (
    conv_done && mode_ff == amcr_pkg::MODE_DUTY |=> low_power_hold_o ##0 !convert_o)
    else $error("duty cycling did not enter standby after conversion");

  a_sync_idle_go: assert property (
    s_sync_start ##0 (state_ff == amcr_pkg::ST_IDLE) &&
    (mode_ff == amcr_pkg::MODE_SYNC_IDLE) |=> convert_o)
    else $error("sync fall did not start a conversion from idle");

  a_sync_low_power_hold_go: assert property (
    s_sync_start ##0 low_power_hold_o && (mode_ff == amcr_pkg::MODE_SYNC_LOW_POWER_HOLD)
    |=> convert_o)
    else $error("sync fall did not start a conversion from standby");

  a_clk_sel_rst: assert property (disable iff (1'b0)
    rst_i |=> clk_sel_ff == amcr_pkg::CLK_INT_QUIET)
    else $error("clock select not zero after reset");

  a_pin_quiet: assert property (
    clk_sel_ff == amcr_pkg::CLK_INT_QUIET |-> !clkpin_oe_o)
    else $error("clock pin driven while output is off");

  a_pin_driven: assert property (
    clk_sel_ff == amcr_pkg::CLK_INT_OUT
    |-> clkpin_oe_o &&
        (!$changed(clkpin_o) || $past(osc_cnt_ff) == amcr_pkg::OSC_HALF_CYC - 12'h001))
    else $error("oscillator not driven on clock pin");

  a_ext_direct: assert property (
    clk_sel_ff == amcr_pkg::CLK_EXT_DIRECT && pin_rise && !ctrl_wr_lo |=> mclk_tick_o)
    else $error("external clock edge gave no main clock tick");

  a_ext_halved: assert property (
    clk_sel_ff == amcr_pkg::CLK_EXT_HALF && pin_rise && !half_ff && !ctrl_wr_lo
    |=> !mclk_tick_o && half_ff)
    else $error("external clock not divided by two");

  a_result_load: assert property (
    conv_done |=> result_ff == $past(sample_i))
    else $error("result not loaded from the finished conversion");

  a_result_hold: assert property (
    !conv_done |=> $stable(result_ff))
    else $error("result changed without a conversion");

  a_result_zero: assert property (disable iff (1'b0)
    rst_i |=> result_ff == 16'h0000)
    else $error("result not zero after reset");

  a_low_power_hold_code: assert property (
    s_mode_set(4'h2) |=> low_power_hold_o [*2])
    else $error("standby code did not enter standby");

endmodule : amcr_core

`default_nettype wire

// ===== amcr_host_model.sv
// Host-side model that drives the external clock pin and the sync pin.
`timescale 1ns/10ps
`default_nettype none
module amcr_host_model (
  input  wire logic       clk_i,     // System clock.
  input  wire logic       run_i,     // Run the external pin clock.
  input  wire logic [7:0] half_i,    // Pin clock half period in system clocks.
  input  wire logic       sync_go_i, // Request one sync pulse.
  output logic            pin_o,     // External clock level.
  output logic            sync_n_o   // Sync pin level.
);
  logic [7:0] cnt_ff;
  logic [2:0] low_ff;

  initial begin
    pin_o    = 1'b0;
    sync_n_o = 1'b1;
    cnt_ff   = 8'h00;
    low_ff   = 3'h0;
  end

  // The pin clock stands still low between runs, as a released line with a pull-down.
  always @(posedge clk_i) begin
    if (!run_i) begin
      pin_o  <= 1'b0;
      cnt_ff <= 8'h00;
    end else if (cnt_ff == half_i - 8'h01) begin
      pin_o  <= ~pin_o;
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  // Each sync pulse is a high-to-low fall held low for four clocks.
  always @(posedge clk_i) begin
    if (sync_go_i) begin
      sync_n_o <= 1'b0;
      low_ff   <= 3'h4;
    end else if (low_ff != 3'h0) begin
      low_ff <= low_ff - 3'h1;
      if (low_ff == 3'h1) begin
        sync_n_o <= 1'b1;
      end
    end
  end
endmodule : amcr_host_model
`default_nettype wire

// ===== adc_mode_clock_and_result_tb.sv
// Self-checking testbench for the converter mode, clock and result block.
`timescale 1ns/10ps
`default_nettype none
module adc_mode_clock_and_result_tb;
  logic        clk_i, rst_i, cyc, stb, we, run, sync_go, ack, oe, pin_o, ext_lvl, sync_n;
  logic        tick, frst, lph, conv, cal;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  logic [15:0] sample;
  logic [1:0]  kind;
  int          n_mismatch, compares;

  amcr_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sync_n_i(sync_n), .clkpin_i(oe ? pin_o : ext_lvl), .clkpin_o(pin_o), .clkpin_oe_o(oe),
    .sample_i(sample), .mclk_tick_o(tick), .filter_rst_o(frst), .low_power_hold_o(lph),
    .convert_o(conv), .cal_active_o(cal), .cal_kind_o(kind));
  amcr_host_model host_u (.clk_i(clk_i), .run_i(run), .half_i(8'h04), .sync_go_i(sync_go),
    .pin_o(ext_lvl), .sync_n_o(sync_n));

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wb_rw(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
    int i;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    // Ack is looked at mid-cycle so the release lands on the edge that samples it high.
    for (i = 0; i < 20; i++) begin
      @(negedge clk_i);
      if (ack === 1'b1) break;
    end
    if (i == 20) begin
      n_mismatch++;
      $display("[ERR] bus ack never came");
      wrap_up();
    end
    @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb_rw

  function automatic logic pick(input int s);
    case (s)
      0:       pick = cal;
      1:       pick = conv;
      2:       pick = frst;
      3:       pick = lph;
      default: pick = 1'b0;
    endcase
  endfunction : pick

  task automatic wait_lvl(input int s, input logic v, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge clk_i);
      if (pick(s) === v) break;
    end
    if (i == lim) begin
      n_mismatch++;
      $display("[ERR] output %0d never reached %b", s, v);
      wrap_up();
    end
  endtask : wait_lvl

  task automatic set_ctrl(input logic [1:0] r, input amcr_pkg::amcr_mode_t m,
                          input amcr_pkg::amcr_clksel_t c);
    logic [31:0] q;
    wb_rw(1'b1, 8'h04, {24'h0, r, m, c}, q);
  endtask : set_ctrl

  task automatic t_reset();
    logic [31:0] q;
    wb_rw(1'b0, 8'h04, 32'h0, q);
    chk("control after reset", 32'h0000_0010, q);
    wb_rw(1'b0, 8'h08, 32'h0, q);
    chk("result after reset", 32'h0, q);
    wb_rw(1'b0, 8'h3c, 32'h0, q);
    chk("unmapped read", 32'h0, q);
    chk("pin enable after reset", 32'h0, 32'(oe));
    chk("filter reset in idle", 32'h1, 32'(frst));
  endtask : t_reset

  task automatic t_clk_int();
    int n;
    logic last;
    set_ctrl(2'h0, amcr_pkg::MODE_IDLE, amcr_pkg::CLK_INT_OUT);
    repeat (3) @(posedge clk_i);
    chk("pin enable, select 01", 32'h1, 32'(oe));
    last = pin_o;
    for (n = 0; n < 3000 && pin_o === last; n++) @(posedge clk_i);
    last = pin_o;
    for (n = 0; n < 3000 && pin_o === last; n++) @(posedge clk_i);
    chk("oscillator half period", 32'(amcr_pkg::OSC_HALF_CYC), n);
    set_ctrl(2'h0, amcr_pkg::MODE_IDLE, amcr_pkg::CLK_INT_QUIET);
    repeat (3) @(posedge clk_i);
    chk("pin enable, select 00", 32'h0, 32'(oe));
  endtask : t_clk_int

  task automatic t_clk_ext(input amcr_pkg::amcr_clksel_t c, input int exp);
    int i, n;
    set_ctrl(2'h0, amcr_pkg::MODE_IDLE, c);
    repeat (40) @(posedge clk_i);
    n = 0;
    for (i = 0; i < 80; i++) begin
      @(posedge clk_i);
      if (tick === 1'b1) n++;
    end
    chk("main ticks in 80 clocks", exp, n);
    chk("pin enable, external", 32'h0, 32'(oe));
  endtask : t_clk_ext

  task automatic t_cal();
    logic [31:0] q;
    for (int m = 5; m <= 8; m++) begin
      set_ctrl(2'h0, amcr_pkg::amcr_mode_t'(m), amcr_pkg::CLK_EXT_DIRECT);
      wait_lvl(0, 1'b1, 10);
      chk("calibration kind", m - 5, 32'(kind));
      wait_lvl(0, 1'b0, 2000);
      wait_lvl(2, 1'b1, 5);
      wb_rw(1'b0, 8'h10, 32'h0, q);
      chk("state after calibration", 32'h0, q);
    end
  endtask : t_cal

  task automatic t_sync(input amcr_pkg::amcr_mode_t m, input int rest, input logic [15:0] s);
    logic [31:0] q;
    set_ctrl(2'h0, m, amcr_pkg::CLK_EXT_DIRECT);
    wait_lvl(rest, 1'b1, 10);
    sample  <= s;
    sync_go <= 1'b1;
    @(posedge clk_i);
    sync_go <= 1'b0;
    wait_lvl(1, 1'b1, 20);
    wait_lvl(1, 1'b0, 500);
    wait_lvl(rest, 1'b1, 5);
    wb_rw(1'b0, 8'h08, 32'h0, q);
    chk("result after sync conversion", {16'h0, s}, q);
    wb_rw(1'b1, 8'h08, 32'h0, q);
    wb_rw(1'b0, 8'h08, 32'h0, q);
    chk("result after write attempt", {16'h0, s}, q);
  endtask : t_sync

  task automatic t_duty();
    int n;
    set_ctrl(2'h1, amcr_pkg::MODE_DUTY, amcr_pkg::CLK_EXT_DIRECT);
    wait_lvl(1, 1'b1, 600);
    chk("standby while converting", 32'h0, 32'(lph));
    wait_lvl(1, 1'b0, 500);
    wait_lvl(3, 1'b1, 5);
    for (n = 0; n < 2000 && lph === 1'b1; n++) @(posedge clk_i);
    chk("standby longer than conversion", 32'h1, 32'(n > 300));
    wait_lvl(1, 1'b1, 20);
  endtask : t_duty

  task automatic t_modes();
    set_ctrl(2'h0, amcr_pkg::MODE_LOW_POWER_HOLD, amcr_pkg::CLK_EXT_DIRECT);
    wait_lvl(3, 1'b1, 10);
    chk("filter reset in standby", 32'h0, 32'(frst));
    set_ctrl(2'h0, amcr_pkg::MODE_IDLE, amcr_pkg::CLK_EXT_DIRECT);
    wait_lvl(2, 1'b1, 10);
    chk("standby in idle", 32'h0, 32'(lph));
  endtask : t_modes

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial begin
    n_mismatch = 0;
    compares   = 0;
    rst_i   = 1'b1;
    cyc     = 1'b0;
    stb     = 1'b0;
    we      = 1'b0;
    adr     = 8'h00;
    sel     = 4'hf;
    wdat    = 32'h0;
    run     = 1'b0;
    sync_go = 1'b0;
    sample  = 16'h0000;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_clk_int();
    run <= 1'b1;
    t_clk_ext(amcr_pkg::CLK_EXT_DIRECT, 10);
    t_clk_ext(amcr_pkg::CLK_EXT_HALF, 5);
    t_cal();
    t_sync(amcr_pkg::MODE_SYNC_IDLE, 2, 16'hbeef);
    t_sync(amcr_pkg::MODE_SYNC_LOW_POWER_HOLD, 3, 16'h1234);
    t_duty();
    t_modes();
    wrap_up();
  end
endmodule : adc_mode_clock_and_result_tb
`default_nettype wire
